//--- logic/dlbr_regs.svh
// Constants for the data line buffer refill block.
`ifndef DLBR_REGS_SVH
`define DLBR_REGS_SVH
`define DLBR_ADDR_W 32
`define DLBR_LINE_W 128
`define DLBR_BEAT_W 64
`define DLBR_OFS_LSB 0
`define DLBR_OFS_MSB 3
`define DLBR_BLK_LSB 4
`define DLBR_HALF_BIT 3
`define DLBR_VALID_RST 1'b0
`define DLBR_DIRTY_RST 1'b0
`endif

//--- logic/dlbr_pkg.sv
// Types shared by the data line buffer refill block.
package dlbr_pkg;
   typedef enum logic [1:0] {
      DLBR_IDLE = 2'b00,
      DLBR_REQ = 2'b01,
      DLBR_BEAT1 = 2'b11,
      DLBR_BEAT2 = 2'b10
   } dlbr_state_e;
   typedef logic [127:0] dlbr_line_t;
endpackage

//--- logic/dlbr_extract.sv
// Byte extraction of a load from the 128-bit line.
`timescale 1ns/100ps
`include "dlbr_regs.svh"
module dlbr_extract (
   input wire logic [`DLBR_LINE_W-1:0] line,
   input wire logic [3:0] offset,
   input wire logic [1:0] size,
   output logic [63:0] data
);
   logic [7:0] bytes [0:15];
   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1) begin : g_byte
         assign bytes[g] = line[8*g+7:8*g];
      end
   endgenerate
   // Bytes past the line end read as zero; loads that cross lines reach this
   // block unsplit and return only the bytes inside the line.
   always_comb begin
      data = 64'h0;
      for (int i = 0; i < 8; i++) begin
         if ((i < (1 << size)) && (32'(offset) + i < 16)) begin
            data[8*i +: 8] = bytes[4'(32'(offset) + i)];
         end
      end
   end
endmodule

//--- logic/dlbr_top.sv
// Data line buffer with two-beat refill on the local memory bus.
`timescale 1ns/100ps
`include "dlbr_regs.svh"
// Notes on behaviour
// - Miss refills whole line by two-beat read.
// - Misaligned load joins both refill beats.
// - Second-beat error reported only if load needs that beat, read never restarted.
// - Cache off: buffer keeps line as cache.
// - Cache off: invalidate drops clean line.
// - Cache on: invalidate also clears buffer.
// - Writeback-invalidate instruction flushes, invalidates buffer.
// - Load to other block replaces line.
module dlbr_top (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic dcache_on,
   input wire logic load_req,
   input wire logic [31:0] load_addr,
   input wire logic [1:0] load_size,
   input wire logic load_cacheable,
   input wire logic cache_invalidate_bit,
   input wire logic line_writeback_invalidate_instr,
   input wire logic wbi_cacheable,
   input wire logic wbi_protected,
   input wire logic buf_write,
   input wire logic [3:0] buf_write_ofs,
   input wire logic [7:0] buf_write_byte,
   input wire logic lmb_gnt,
   input wire logic lmb_rvalid,
   input wire logic lmb_err,
   input wire logic [63:0] lmb_rdata,
   output logic load_ready,
   output logic load_done,
   output logic load_err,
   output logic [63:0] load_data,
   output logic lmb_req,
   output logic [31:0] lmb_addr,
   output logic flush_req,
   output logic [127:0] flush_data,
   output logic [31:0] flush_addr,
   output logic line_valid,
   output logic line_dirty
);
   dlbr_pkg::dlbr_state_e state;
   dlbr_pkg::dlbr_line_t line;
   logic [27:0] tag;
   logic [31:0] pend_addr;
   logic [1:0] pend_size;
   logic [63:0] extract_data;
   logic hit;
   logic inval_now;
   logic [3:0] last_ofs;

   function automatic logic needs_high(input logic [3:0] ofs,
                                       input logic [1:0] sz);
      needs_high = (5'(ofs) + (5'd1 << sz) - 5'd1) >= 5'd8;
   endfunction

   assign hit = line_valid && tag == load_addr[31:`DLBR_BLK_LSB];
   // Clean-only drop when cache is off; always when on.
   assign inval_now = (cache_invalidate_bit && !dcache_on && !line_dirty)
      || (cache_invalidate_bit && dcache_on)
      || (line_writeback_invalidate_instr && wbi_cacheable
          && !wbi_protected);
   assign last_ofs = pend_addr[`DLBR_OFS_MSB:`DLBR_OFS_LSB];

   dlbr_extract u_extract (
      .line(line),
      .offset(last_ofs),
      .size(pend_size),
      .data(extract_data)
   );

   // Refill sequencer; a second-beat error ends the load, no retry.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state <= dlbr_pkg::DLBR_IDLE;
         pend_addr <= 32'h0;
         pend_size <= 2'h0;
         lmb_req <= 1'b0;
         lmb_addr <= 32'h0;
         load_ready <= 1'b0;
         load_done <= 1'b0;
         load_err <= 1'b0;
         load_data <= 64'h0;
      end else begin
         load_done <= 1'b0;
         load_err <= 1'b0;
         case (state)
            dlbr_pkg::DLBR_IDLE: begin
               load_ready <= 1'b1;
               if (load_req && load_ready && load_cacheable) begin
                  pend_addr <= load_addr;
                  pend_size <= load_size;
                  load_ready <= 1'b0;
                  if (hit && !inval_now) begin
                     state <= dlbr_pkg::DLBR_BEAT2;
                  end else begin
                     lmb_req <= 1'b1;
                     lmb_addr <= {load_addr[31:`DLBR_BLK_LSB], 4'h0};
                     state <= dlbr_pkg::DLBR_REQ;
                  end
               end
            end
            dlbr_pkg::DLBR_REQ: begin
               if (lmb_gnt) begin
                  lmb_req <= 1'b0;
                  state <= dlbr_pkg::DLBR_BEAT1;
               end
            end
            dlbr_pkg::DLBR_BEAT1: begin
               if (lmb_rvalid && lmb_err) begin
                  load_done <= 1'b1;
                  load_err <= 1'b1;
                  state <= dlbr_pkg::DLBR_IDLE;
               end else if (lmb_rvalid) begin
                  state <= dlbr_pkg::DLBR_BEAT2;
               end
            end
            dlbr_pkg::DLBR_BEAT2: begin
               if (line_valid) begin
                  // Hit path or completed refill: answer from the line.
                  load_done <= 1'b1;
                  load_data <= extract_data;
                  state <= dlbr_pkg::DLBR_IDLE;
               end else if (lmb_rvalid) begin
                  // Second beat error is only fatal if the load needs it.
                  load_err <= lmb_err && needs_high(last_ofs, pend_size);
                  load_done <= lmb_err;
                  // A load held in the first half is still served from beat one.
                  load_data <= extract_data;
                  if (lmb_err) begin
                     state <= dlbr_pkg::DLBR_IDLE;
                  end
               end
            end
            default: state <= dlbr_pkg::DLBR_IDLE;
         endcase
      end
   end

   // Line storage, tag and valid state.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         line <= 128'h0;
         tag <= 28'h0;
         line_valid <= `DLBR_VALID_RST;
      end else begin
         if (state == dlbr_pkg::DLBR_REQ) begin
            line_valid <= 1'b0;
            tag <= pend_addr[31:`DLBR_BLK_LSB];
         end else if (state == dlbr_pkg::DLBR_BEAT1 && lmb_rvalid) begin
            line[63:0] <= lmb_rdata;
         end else if (state == dlbr_pkg::DLBR_BEAT2 && !line_valid
                      && lmb_rvalid) begin
            line[127:64] <= lmb_rdata;
            line_valid <= !lmb_err;
         end else if (inval_now && state == dlbr_pkg::DLBR_IDLE) begin
            line_valid <= 1'b0;
         end else if (buf_write && line_valid && !dcache_on) begin
            line[8*buf_write_ofs +: 8] <= buf_write_byte;
         end
      end
   end

   // Dirty tracking and flush on the writeback-invalidate instruction.
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         line_dirty <= `DLBR_DIRTY_RST;
         flush_req <= 1'b0;
         flush_data <= 128'h0;
         flush_addr <= 32'h0;
      end else begin
         flush_req <= 1'b0;
         if (state == dlbr_pkg::DLBR_IDLE && line_writeback_invalidate_instr
             && wbi_cacheable && !wbi_protected) begin
            flush_req <= line_dirty && line_valid;
            flush_data <= line;
            flush_addr <= {tag, 4'h0};
            line_dirty <= 1'b0;
         end else if (state == dlbr_pkg::DLBR_REQ) begin
            line_dirty <= 1'b0;
         end else if (buf_write && line_valid && !dcache_on) begin
            line_dirty <= 1'b1;
         end
      end
   end

   chk_err_no_retry: assert property (@(posedge core_clk) disable iff (!rst_n)
      load_err |=> !lmb_req [*2])
      else $error("refill restarted after error");
   chk_inval_clears_valid: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (inval_now && state == dlbr_pkg::DLBR_IDLE && !load_req) |=>
      !line_valid)
      else $error("invalidate left line valid");
   chk_miss_requests: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (state == dlbr_pkg::DLBR_IDLE && load_req && load_ready
       && load_cacheable && !hit) |=> lmb_req)
      else $error("miss did not request refill");
   chk_two_beats: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(line_valid) |-> $past(state) == dlbr_pkg::DLBR_BEAT2)
      else $error("line valid without second beat");
   chk_cache_on_inval: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      (cache_invalidate_bit && dcache_on && state == dlbr_pkg::DLBR_IDLE
       && !load_req) |=> !line_valid)
      else $error("cache on invalidate missed buffer");
   chk_dirty_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cache_invalidate_bit && !dcache_on && line_dirty && line_valid
       && !line_writeback_invalidate_instr && state == dlbr_pkg::DLBR_IDLE
       && !load_req) |=> line_valid)
      else $error("dirty line dropped by invalidate");
   chk_wbi_flush: assert property (@(posedge core_clk) disable iff (!rst_n)
      (line_writeback_invalidate_instr && wbi_cacheable && !wbi_protected
       && state == dlbr_pkg::DLBR_IDLE && !load_req) |=>
      (!line_valid && !line_dirty))
      else $error("writeback invalidate ignored");
   chk_other_block: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == dlbr_pkg::DLBR_REQ) |=> !line_valid)
      else $error("old line kept on replace");
   chk_hit_served: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state == dlbr_pkg::DLBR_IDLE && load_req && load_ready
       && load_cacheable && hit && !inval_now) |-> ##2 load_done)
      else $error("hit not served in two cycles");
endmodule

//--- verification/dlbr_mem_model.sv
// Memory bus slave that answers two-beat line reads.
`timescale 1ns/100ps
module dlbr_mem_model (
   input wire logic clk,
   input wire logic req,
   input wire logic [31:0] addr,
   input wire logic [7:0] gen,
   input wire logic [1:0] err_beat,
   input wire logic [2:0] stall,
   output logic gnt,
   output logic rvalid,
   output logic err,
   output logic [63:0] rdata,
   output int reqs
);
   initial begin
      logic [31:0] a;
      gnt = 0;
      rvalid = 0;
      err = 0;
      rdata = 0;
      reqs = 0;
      forever begin
         @(posedge clk);
         if (req) begin
            repeat (stall) @(posedge clk);
            a = addr;
            gnt <= 1'b1;
            @(posedge clk);
            gnt <= 1'b0;
            reqs <= reqs + 1;
            for (int b = 0; b < 2; b++) begin
               rvalid <= 1'b1;
               err <= err_beat[b];
               for (int i = 0; i < 8; i++) begin
                  rdata[8*i+:8] <= a[7:0] + 8'(8*b+i) ^ gen;
               end
               @(posedge clk);
            end
            rvalid <= 1'b0;
            err <= 1'b0;
            // Released data is inverted so a late sample cannot match.
            rdata <= ~rdata;
         end
      end
   end
endmodule

//--- verification/test_dlbr_top.sv
// Self-checking bench for the data line buffer refill block.
`timescale 1ns/100ps
module test_dlbr_top;
   logic core_clk = 0, rst_n = 0, dcache_on = 0, load_req = 0, buf_write = 0;
   logic load_cacheable = 1, cache_invalidate_bit = 0, wbi_cacheable = 1;
   logic line_writeback_invalidate_instr = 0, wbi_protected = 0;
   logic lmb_gnt, lmb_rvalid, lmb_err, lmb_req, load_ready, load_done;
   logic load_err, line_valid, line_dirty, lv = 0, dirty = 0, fr;
   logic [31:0] load_addr = 0, lmb_addr;
   logic [1:0] load_size = 0, eb = 0;
   logic [3:0] buf_write_ofs = 0;
   logic [7:0] buf_write_byte = 0, gen = 0, lb[16];
   logic [2:0] stall = 0;
   logic [63:0] lmb_rdata, load_data;
   logic [65:0] ex, q[$];
   logic [27:0] blk;
   int error_cnt = 0, checks_done = 0, exp_reqs = 0, reqs, seed;
   always #10 core_clk = ~core_clk;
   dlbr_top u_dlbr_top (.core_clk, .rst_n, .dcache_on, .load_req,
      .load_addr, .load_size, .load_cacheable, .cache_invalidate_bit,
      .line_writeback_invalidate_instr, .wbi_cacheable, .wbi_protected,
      .buf_write, .buf_write_ofs, .buf_write_byte, .lmb_gnt, .lmb_rvalid,
      .lmb_err, .lmb_rdata, .load_ready, .load_done, .load_err, .load_data,
      .lmb_req, .lmb_addr, .flush_req(fr), .flush_data(), .flush_addr(),
      .line_valid, .line_dirty);
   dlbr_mem_model u_dlbr_mem_model (.clk(core_clk), .req(lmb_req),
      .addr(lmb_addr), .gen, .err_beat(eb), .stall, .gnt(lmb_gnt),
      .rvalid(lmb_rvalid), .err(lmb_err), .rdata(lmb_rdata), .reqs);
   task automatic check(string nm, logic [63:0] e, logic [63:0] g);
      checks_done++;
      if (e !== g) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic idle();
      for (int k = 0; k < 50 && load_ready !== 1'b1; k++) begin
         @(posedge core_clk);
         #1;
      end
   endtask
   always @(posedge core_clk) begin
      if (load_done === 1'b1) begin
         ex = q.size() ? q.pop_front() : '1;
         check("load_err", ex[64], load_err);
         if (ex[65]) check("load_data", ex[63:0], load_data);
      end
   end
   task automatic ctl(int k);
      idle();
      buf_write_ofs = 4'($urandom);
      buf_write_byte = 8'($urandom);
      cache_invalidate_bit = (k == 0);
      line_writeback_invalidate_instr = (k == 1);
      buf_write = (k == 2);
      @(posedge core_clk);
      #1;
      {cache_invalidate_bit, line_writeback_invalidate_instr, buf_write} = 0;
      if (k == 1) check("flush_req", lv && dirty, fr);
      if (k == 0 && (dcache_on || !dirty)) lv = 0;
      if (k == 1) {lv, dirty} = 0;
      if (k == 2 && lv && !dcache_on) begin
         dirty = 1;
         lb[buf_write_ofs] = buf_write_byte;
      end
      @(posedge core_clk);
      #1;
      if (!dcache_on) check("line_valid", lv, line_valid);
      if (!dcache_on) check("line_dirty", dirty, line_dirty);
   endtask
   task automatic do_load(logic [31:0] a, logic [1:0] sz, logic [1:0] e);
      logic [63:0] d;
      logic x;
      int n;
      n = 1 << sz;
      d = 0;
      x = 0;
      eb = e;
      stall = 3'($urandom);
      idle();
      if (!(lv && blk === a[31:4])) begin
         exp_reqs++;
         blk = a[31:4];
         for (int i = 0; i < 16; i++) lb[i] = {a[7:4], 4'(i)} ^ gen;
         x = e[0] || (e[1] && a[3:0] + n > 8);
         lv = !e;
         dirty = 0;
      end
      for (int i = 0; i < n; i++) begin
         if (a[3:0] + i < 16) d[8*i+:8] = lb[a[3:0]+i];
      end
      q.push_back({!x, x, d});
      {load_req, load_addr, load_size} = {1'b1, a, sz};
      @(posedge core_clk);
      #1;
      load_req = 0;
      for (int k = 0; k < 40 && q.size(); k++) @(posedge core_clk);
      // Extra cycles let a wrongly restarted read reach the counter.
      repeat (4) @(posedge core_clk);
      #1;
      check("pending", 0, q.size());
      check("requests", exp_reqs, reqs);
      if (!dcache_on) check("line_valid", lv, line_valid);
   endtask
   initial begin
      #400000;
      error_cnt++;
      summarize();
   end
   initial begin
      seed = $urandom(51112);
      repeat (10) @(posedge core_clk);
      #1;
      rst_n = 1;
      do_load(32'h8000_0016, 2, 0);
      gen = 8'h11;
      do_load(32'h8000_0010, 3, 0);
      do_load(32'h8000_0020, 2, 0);
      do_load(32'h8000_0014, 1, 0);
      ctl(0);
      do_load(32'h8000_0014, 0, 0);
      ctl(2);
      ctl(0);
      do_load(32'h8000_0010, 3, 0);
      ctl(1);
      do_load(32'h8000_001e, 2, 0);
      dcache_on = 1;
      ctl(0);
      do_load(32'h8000_0016, 2, 0);
      ctl(1);
      dcache_on = 0;
      do_load(32'h8000_0036, 2, 2'b10);
      do_load(32'h8000_0030, 2, 2'b10);
      do_load(32'h8000_0038, 2, 2'b01);
      repeat (40) begin
         gen = 8'($urandom);
         if ($urandom % 4 == 0) ctl($urandom % 3);
         do_load(32'h8000_0000 + $urandom % 48, 2'($urandom),
            ($urandom % 6 == 0) ? 2'b10 : 2'b00);
      end
      summarize();
   end
endmodule
